// *** src/pdh_pkg.sv ***
// Constants, types and host-port decode for the palette DAC front end.
// Assumes one 25 MHz clock; strobes and pixel pins synchronous to it.
package pdh_pkg;

  // Register-select codes
  localparam logic [2:0] SEL_PAL_WIDX = 3'h0;
  localparam logic [2:0] SEL_PAL_DATA = 3'h1;
  localparam logic [2:0] SEL_MASK = 3'h2;
  localparam logic [2:0] SEL_PAL_RIDX = 3'h3;
  localparam logic [2:0] SEL_OVL_WIDX = 3'h4;
  localparam logic [2:0] SEL_OVL_DATA = 3'h5;
  localparam logic [2:0] SEL_CMD = 3'h6;
  localparam logic [2:0] SEL_OVL_RIDX = 3'h7;

  // Command register field: six-bit colour mode select
  localparam int CMD_SIX_BIT_POS = 1;

  // Reset values; command register has no documented init
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [7:0] INDEX_RESET = 8'h00;

  localparam logic [1:0] PHASE_RED = 2'h0;
  localparam logic [1:0] PHASE_GREEN = 2'h1;
  localparam logic [1:0] PHASE_BLUE = 2'h2;

  localparam logic [7:0] INDEX_LAST = 8'hFF;
  localparam logic [3:0] OVL_NONE = 4'h0;
  localparam logic [7:0] BLANK_CODE = 8'h00;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } pdh_host_state_type;

endpackage

// *** src/pdh_pixel_stage.sv ***
// One stage of the pixel pipeline: registers colour, sync and blank.
// Assumes the caller has already chosen the colour for this pixel.
`timescale 1ns/1ps
module pdh_pixel_stage
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [23:0] rgb_in,
  input wire logic sync_n_in,
  input wire logic blank_n_in,
  output logic [23:0] rgb_out,
  output logic sync_n_out,
  output logic blank_n_out
);

  typedef struct packed
  {
    logic [23:0] rgb;
    logic sync_n;
    logic blank_n;
  } pdh_stage_type;

  pdh_stage_type st_q;
  pdh_stage_type st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.rgb = rgb_in;
    st_d.sync_n = sync_n_in;
    st_d.blank_n = blank_n_in;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_q <= '0;
    end
    else if (ce)
    begin
      st_q <= st_d;
    end
  end

  assign rgb_out = st_q.rgb;
  assign sync_n_out = st_q.sync_n;
  assign blank_n_out = st_q.blank_n;

endmodule

// *** src/pdh_top.sv ***
// Host port, palette store and pixel front end of the palette DAC.
// Assumes strobes are synchronous to CLK and held at least two cycles.
`timescale 1ns/1ps
module pdh_top
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic [2:0] REGISTER_SELECT,
  input wire logic [7:0] HOST_DATA_BUS_IN,
  output logic [7:0] HOST_DATA_BUS_OUT,
  output logic HOST_DATA_BUS_OE,
  output logic [7:0] CONTROL_OUTPUT_PINS,
  input wire logic [7:0] RED_PIXEL_IN,
  input wire logic [7:0] GREEN_PIXEL_IN,
  input wire logic [7:0] BLUE_PIXEL_IN,
  input wire logic [1:0] COLOR_MODE_SELECT,
  input wire logic [3:0] OVERLAY_SELECT,
  input wire logic SYNC_N,
  input wire logic BLANK_N,
  output logic [7:0] RED_LEVEL,
  output logic [7:0] GREEN_LEVEL,
  output logic [7:0] BLUE_LEVEL,
  output logic SYNC_LEVEL_ON,
  output logic BLANK_ACTIVE
);

  ////////////////////////////////////////////////////////////////////////
  // Storage

  logic [23:0] palette_mem [256];
  logic [23:0] overlay_mem [16];

  typedef struct packed
  {
    pdh_pkg::pdh_host_state_type state;
    logic [2:0] sel;
    logic [7:0] index;
    logic [1:0] phase;
    logic ovl_mode;
    logic [7:0] red_hold;
    logic [7:0] green_hold;
    logic [7:0] blue_hold;
    logic [7:0] cmd;
    logic [7:0] mask;
    logic [7:0] dout;
    logic doe;
    logic [7:0] red_px;
    logic [7:0] green_px;
    logic [7:0] blue_px;
    logic [1:0] mode_px;
    logic [3:0] ovl_px;
    logic sync_px;
    logic blank_px;
  } pdh_top_type;

  pdh_top_type s_q;
  pdh_top_type s_d;

  logic mem_we;
  logic ovl_we;
  logic [7:0] mem_waddr;
  logic [23:0] mem_wdata;
  logic [23:0] rd_entry;
  logic six_bit;
  logic [7:0] wr_byte;
  logic [7:0] step_index;

  assign six_bit = s_q.cmd[pdh_pkg::CMD_SIX_BIT_POS];

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Six-bit colour lives in the low bits of the data bus
  function automatic logic [7:0] trim_colour(input logic [7:0] v,
                                             input logic six);
    trim_colour = six ? {2'b00, v[5:0]} : v;
  endfunction

  // Overlay index keeps only the low nibble
  function automatic logic [23:0] fetch(input logic ovl,
                                        input logic [7:0] idx);
    fetch = ovl ? overlay_mem[idx[3:0]] : palette_mem[idx];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Host port state

  always_comb
  begin
    s_d = s_q;
    mem_we = 1'b0;
    ovl_we = 1'b0;
    mem_waddr = s_q.index;
    mem_wdata = {s_q.red_hold, s_q.green_hold, s_q.blue_hold};
    rd_entry = 24'h0000_00;
    wr_byte = trim_colour(HOST_DATA_BUS_IN, six_bit);
    // Wrap to zero past the last location is natural 8-bit overflow
    step_index = s_q.index + 8'h01;
    unique case (s_q.state)
      pdh_pkg::ST_IDLE:
      begin
        s_d.doe = 1'b0;
        // Select taken in the cycle either strobe is first seen low
        s_d.sel = REGISTER_SELECT;
        if (!RD_N)
          s_d.state = pdh_pkg::ST_READ;
        else if (!WR_N)
          s_d.state = pdh_pkg::ST_WRITE;
      end
      pdh_pkg::ST_READ:
      begin
        s_d.doe = 1'b1;
        unique case (s_q.sel)
          pdh_pkg::SEL_PAL_DATA, pdh_pkg::SEL_OVL_DATA:
            unique case (s_q.phase)
              pdh_pkg::PHASE_GREEN:
                s_d.dout = trim_colour(s_q.green_hold, six_bit);
              pdh_pkg::PHASE_BLUE:
                s_d.dout = trim_colour(s_q.blue_hold, six_bit);
              default:
                s_d.dout = trim_colour(s_q.red_hold, six_bit);
            endcase
          pdh_pkg::SEL_MASK: s_d.dout = s_q.mask;
          pdh_pkg::SEL_CMD: s_d.dout = s_q.cmd;
          // Index read leaves phase and mode untouched
          default: s_d.dout = s_q.index;
        endcase
        if (RD_N)
        begin
          s_d.doe = 1'b0;
          s_d.state = pdh_pkg::ST_IDLE;
          if (s_q.sel[1:0] == pdh_pkg::SEL_PAL_DATA[1:0])
          begin
            if (s_q.phase == pdh_pkg::PHASE_BLUE)
            begin
              // Refill holds from the current index, then step past it
              rd_entry = fetch(s_q.ovl_mode, s_q.index);
              s_d.red_hold = rd_entry[23:16];
              s_d.green_hold = rd_entry[15:8];
              s_d.blue_hold = rd_entry[7:0];
              s_d.index = step_index;
              s_d.phase = pdh_pkg::PHASE_RED;
            end
            else
              s_d.phase = s_q.phase + 2'h1;
          end
        end
      end
      pdh_pkg::ST_WRITE:
      begin
        if (WR_N)
        begin
          // Data captured on the rising edge of the write strobe
          s_d.state = pdh_pkg::ST_IDLE;
          unique case (s_q.sel)
            pdh_pkg::SEL_PAL_WIDX, pdh_pkg::SEL_OVL_WIDX:
            begin
              s_d.index = HOST_DATA_BUS_IN;
              s_d.phase = pdh_pkg::PHASE_RED;
              s_d.ovl_mode = s_q.sel[2];
            end
            pdh_pkg::SEL_PAL_RIDX, pdh_pkg::SEL_OVL_RIDX:
            begin
              s_d.ovl_mode = s_q.sel[2];
              s_d.phase = pdh_pkg::PHASE_RED;
              rd_entry = fetch(s_q.sel[2], HOST_DATA_BUS_IN);
              s_d.red_hold = rd_entry[23:16];
              s_d.green_hold = rd_entry[15:8];
              s_d.blue_hold = rd_entry[7:0];
              s_d.index = HOST_DATA_BUS_IN + 8'h01;
            end
            pdh_pkg::SEL_PAL_DATA, pdh_pkg::SEL_OVL_DATA:
            begin
              unique case (s_q.phase)
                pdh_pkg::PHASE_GREEN:
                begin
                  s_d.green_hold = wr_byte;
                  s_d.phase = pdh_pkg::PHASE_BLUE;
                end
                pdh_pkg::PHASE_BLUE:
                begin
                  // Blue completes the triplet and stores it
                  mem_wdata = {s_q.red_hold, s_q.green_hold, wr_byte};
                  mem_we = ~s_q.ovl_mode;
                  ovl_we = s_q.ovl_mode;
                  s_d.blue_hold = wr_byte;
                  s_d.index = step_index;
                  s_d.phase = pdh_pkg::PHASE_RED;
                end
                default:
                begin
                  s_d.red_hold = wr_byte;
                  s_d.phase = pdh_pkg::PHASE_GREEN;
                end
              endcase
            end
            pdh_pkg::SEL_MASK: s_d.mask = HOST_DATA_BUS_IN;
            default: s_d.cmd = HOST_DATA_BUS_IN;
          endcase
        end
      end
      default:
      begin
        s_d.state = pdh_pkg::ST_IDLE;
        s_d.doe = 1'b0;
      end
    endcase

    // Pixel capture every clock that CE is high
    s_d.red_px = RED_PIXEL_IN;
    s_d.green_px = GREEN_PIXEL_IN;
    s_d.blue_px = BLUE_PIXEL_IN;
    s_d.mode_px = COLOR_MODE_SELECT;
    s_d.ovl_px = OVERLAY_SELECT;
    s_d.sync_px = SYNC_N;
    s_d.blank_px = BLANK_N;
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      s_q <= '0;
      s_q.state <= pdh_pkg::ST_IDLE;
      s_q.cmd <= pdh_pkg::CMD_RESET;
      s_q.mask <= pdh_pkg::MASK_RESET;
      s_q.index <= pdh_pkg::INDEX_RESET;
      s_q.sync_px <= 1'b1;
    end
    else if (CE)
      s_q <= s_d;
  end

  // Memories carry no reset; contents are undefined until loaded
  always_ff @(posedge CLK)
  begin
    if (CE && mem_we)
      palette_mem[mem_waddr] <= mem_wdata;
    if (CE && ovl_we)
      overlay_mem[mem_waddr[3:0]] <= mem_wdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // Pixel path

  logic [23:0] pix_colour;
  logic [23:0] look_up;

  // Mode select only affects bypass; blank wins over overlay, overlay over everything else
  always_comb
  begin
    look_up = {palette_mem[s_q.red_px & s_q.mask][23:16],
               palette_mem[s_q.green_px & s_q.mask][15:8],
               palette_mem[s_q.blue_px & s_q.mask][7:0]};
    if (!s_q.blank_px)
      pix_colour = {3{pdh_pkg::BLANK_CODE}};
    else if (s_q.ovl_px != pdh_pkg::OVL_NONE)
      pix_colour = overlay_mem[s_q.ovl_px];
    else if (s_q.mode_px[0])
      pix_colour = {s_q.red_px, s_q.green_px, s_q.blue_px};
    else
      pix_colour = look_up;
  end

  logic [23:0] out_rgb;
  logic out_sync_n;
  logic out_blank_n;

  // Sync passes on its own, never altering colour
  pdh_pixel_stage pdh_pixel_stage_i
  (
    .clk(CLK),
    .reset(RESET),
    .ce(CE),
    .rgb_in(pix_colour),
    .sync_n_in(s_q.sync_px),
    .blank_n_in(s_q.blank_px),
    .rgb_out(out_rgb),
    .sync_n_out(out_sync_n),
    .blank_n_out(out_blank_n)
  );

  assign RED_LEVEL = out_rgb[23:16];
  assign GREEN_LEVEL = out_rgb[15:8];
  assign BLUE_LEVEL = out_rgb[7:0];
  assign SYNC_LEVEL_ON = out_sync_n;
  assign BLANK_ACTIVE = ~out_blank_n;
  assign HOST_DATA_BUS_OUT = s_q.dout;
  assign HOST_DATA_BUS_OE = s_q.doe;
  assign CONTROL_OUTPUT_PINS = s_q.cmd;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  sequence seq_red_write;
    s_q.state == pdh_pkg::ST_WRITE && WR_N && s_q.phase == 2'h0;
  endsequence

  AST_OE_ONLY_READ: assert property (@(posedge CLK) disable iff (RESET)
    HOST_DATA_BUS_OE |-> s_q.state == pdh_pkg::ST_READ)
    else $error("bus driven outside read");
  AST_CTRL_PINS: assert property (@(posedge CLK) disable iff (RESET)
    CE && $past(CE) && s_q.state == pdh_pkg::ST_WRITE && WR_N &&
    s_q.sel == pdh_pkg::SEL_CMD |=> CONTROL_OUTPUT_PINS == $past(
    HOST_DATA_BUS_IN))
    else $error("control pins not following command");
  AST_IDX_CLR: assert property (@(posedge CLK) disable iff (RESET)
    CE && s_q.state == pdh_pkg::ST_WRITE && WR_N &&
    s_q.sel[1:0] inside {2'h0, 2'h3} |=> s_q.phase == pdh_pkg::PHASE_RED)
    else $error("phase not cleared on index write");
  AST_PHASE_RANGE: assert property (@(posedge CLK) disable iff (RESET)
    s_q.phase != 2'h3)
    else $error("phase counter left modulo three");
  AST_PHASE_STEP: assert property (@(posedge CLK) disable iff (RESET)
    CE and seq_red_write and (s_q.sel == pdh_pkg::SEL_PAL_DATA)
    |=> s_q.phase == pdh_pkg::PHASE_GREEN)
    else $error("phase did not step after red");
  AST_BLANK_OUT: assert property (@(posedge CLK) disable iff (RESET)
    CE && !s_q.blank_px |=> BLANK_ACTIVE &&
    {RED_LEVEL, GREEN_LEVEL, BLUE_LEVEL} == {3{pdh_pkg::BLANK_CODE}})
    else $error("blank not forcing outputs");
  AST_BLUE_STEP: assert property (@(posedge CLK) disable iff (RESET)
    CE && s_q.state == pdh_pkg::ST_WRITE && WR_N && s_q.phase == 2'h2 &&
    s_q.sel == pdh_pkg::SEL_PAL_DATA |=> s_q.index == $past(s_q.index) +
    8'h01)
    else $error("index not stepped after blue");
  AST_SIX_BIT_READ: assert property (@(posedge CLK) disable iff (RESET)
    HOST_DATA_BUS_OE && six_bit && s_q.sel[1:0] == 2'h1 &&
    $stable(s_q.sel) && $past(HOST_DATA_BUS_OE) |-> s_q.dout[7:6] == 2'h0)
    else $error("upper bits not zero in six-bit read");
  AST_PIXEL_LATCH: assert property (@(posedge CLK) disable iff (RESET)
    CE |=> s_q.red_px == $past(RED_PIXEL_IN) &&
    s_q.ovl_px == $past(OVERLAY_SELECT))
    else $error("pixel inputs not captured");

endmodule

// *** tb/pdh_host_model.sv ***
// Host processor side of the palette port: strobed reads and writes.
// Assumes strobes are sampled on the rising edge of clk by the device.
`timescale 1ns/1ps
module pdh_host_model
(
  input wire logic clk,
  output logic rd_n,
  output logic wr_n,
  output logic [2:0] sel,
  output logic [7:0] dout,
  input wire logic [7:0] din
);
  initial
  begin
    rd_n = 1'b1;
    wr_n = 1'b1;
    sel = 3'h0;
    dout = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // Only one strobe is ever low; each task ends with both high
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk);
    wr_n <= 1'b0;
    sel <= s;
    dout <= d;
    repeat (2) @(posedge clk);
    wr_n <= 1'b1;
    repeat (2) @(posedge clk);
    // Released bus shows the inverse, not a stale copy
    dout <= ~d;
  endtask

  task automatic rd(input logic [2:0] s, output logic [7:0] d);
    @(posedge clk);
    rd_n <= 1'b0;
    sel <= s;
    repeat (3) @(posedge clk);
    d = din;
    rd_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
endmodule

// *** tb/pdh_top_tb.sv ***
// Self-checking bench for the palette DAC host and pixel port.
// Assumes the host model file is compiled first.
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module pdh_top_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic rd_n, wr_n, oe, sync_n = 1'b1, blank_n = 1'b1, ce = 1'b1;
  logic [2:0] sel;
  logic [7:0] hdout, dout, bus, pins, rl, gl, bl, v;
  logic [23:0] pix = 24'h0000_00;
  logic [1:0] mode = 2'h0;
  logic [3:0] ovl = 4'h0;
  logic sync_on, blank_act;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #20 clk = ~clk;
  // Wire level: device wins only while it enables its driver
  assign bus = oe ? dout : hdout;

  pdh_host_model pdh_host_model_i (.clk(clk), .rd_n(rd_n), .wr_n(wr_n),
    .sel(sel), .dout(hdout), .din(bus));

  pdh_top pdh_top_i (.CLK(clk), .RESET(reset), .CE(ce), .RD_N(rd_n),
    .WR_N(wr_n), .REGISTER_SELECT(sel), .HOST_DATA_BUS_IN(bus),
    .HOST_DATA_BUS_OUT(dout), .HOST_DATA_BUS_OE(oe),
    .CONTROL_OUTPUT_PINS(pins), .RED_PIXEL_IN(pix[23:16]),
    .GREEN_PIXEL_IN(pix[15:8]), .BLUE_PIXEL_IN(pix[7:0]),
    .COLOR_MODE_SELECT(mode), .OVERLAY_SELECT(ovl), .SYNC_N(sync_n),
    .BLANK_N(blank_n), .RED_LEVEL(rl), .GREEN_LEVEL(gl), .BLUE_LEVEL(bl),
    .SYNC_LEVEL_ON(sync_on), .BLANK_ACTIVE(blank_act));

  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      end_of_test;
    end
  end

  task automatic wreg(input logic [2:0] s, input logic [7:0] d);
    pdh_host_model_i.wr(s, d);
    `CHK(oe, 1'b0)
  endtask

  task automatic rchk(input logic [2:0] s, input logic [7:0] e);
    pdh_host_model_i.rd(s, v);
    `CHK(v, e)
    `CHK(oe, 1'b0)
  endtask

  // Reads a colour triplet from a data port
  task automatic rgb_chk(input logic [2:0] s, input logic [23:0] e);
    rchk(s, e[23:16]);
    rchk(s, e[15:8]);
    rchk(s, e[7:0]);
  endtask

  task automatic rgb_wr(input logic [2:0] s, input logic [23:0] d);
    wreg(s, d[23:16]);
    wreg(s, d[15:8]);
    wreg(s, d[7:0]);
  endtask

  // Pixel inputs held long enough to cover the two-stage pipeline
  task automatic px(input logic [23:0] p, input logic [1:0] m,
    input logic [3:0] o, input logic s, input logic b);
    @(posedge clk);
    pix <= p;
    mode <= m;
    ovl <= o;
    sync_n <= s;
    blank_n <= b;
    repeat (4) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    rchk(pdh_pkg::SEL_CMD, pdh_pkg::CMD_RESET);
    rchk(pdh_pkg::SEL_MASK, pdh_pkg::MASK_RESET);
    wreg(pdh_pkg::SEL_CMD, 8'hA5);
    `CHK(pins, 8'hA5)
    rchk(pdh_pkg::SEL_CMD, 8'hA5);
    // Last two entries of the palette; index then wraps to zero
    wreg(pdh_pkg::SEL_PAL_WIDX, 8'hFE);
    rgb_wr(pdh_pkg::SEL_PAL_DATA, 24'h1122_33);
    rgb_wr(pdh_pkg::SEL_PAL_DATA, 24'h4455_66);
    rchk(pdh_pkg::SEL_PAL_WIDX, 8'h00);
    // Partial triplet then index rewrite restarts at red
    wreg(pdh_pkg::SEL_PAL_WIDX, 8'h10);
    wreg(pdh_pkg::SEL_PAL_DATA, 8'hAA);
    rchk(pdh_pkg::SEL_PAL_WIDX, 8'h10);
    wreg(pdh_pkg::SEL_PAL_WIDX, 8'h10);
    rgb_wr(pdh_pkg::SEL_PAL_DATA, 24'h0102_03);
    wreg(pdh_pkg::SEL_PAL_RIDX, 8'hFE);
    rgb_chk(pdh_pkg::SEL_PAL_DATA, 24'h1122_33);
    rgb_chk(pdh_pkg::SEL_PAL_DATA, 24'h4455_66);
    wreg(pdh_pkg::SEL_PAL_RIDX, 8'h10);
    rgb_chk(pdh_pkg::SEL_PAL_DATA, 24'h0102_03);
    // Six-bit colour width
    wreg(pdh_pkg::SEL_CMD, 8'h02);
    wreg(pdh_pkg::SEL_PAL_WIDX, 8'h20);
    rgb_wr(pdh_pkg::SEL_PAL_DATA, 24'hFFC1_80);
    wreg(pdh_pkg::SEL_PAL_RIDX, 8'h20);
    rgb_chk(pdh_pkg::SEL_PAL_DATA, 24'h3F01_00);
    wreg(pdh_pkg::SEL_CMD, 8'h00);
    // Overlay index upper nibble is ignored
    wreg(pdh_pkg::SEL_OVL_WIDX, 8'h13);
    rgb_wr(pdh_pkg::SEL_OVL_DATA, 24'h7A7B_7C);
    wreg(pdh_pkg::SEL_OVL_RIDX, 8'h03);
    rgb_chk(pdh_pkg::SEL_OVL_DATA, 24'h7A7B_7C);
    // Pixel port
    px(24'hFEFF_10, 2'h0, 4'h0, 1'b1, 1'b1);
    `CHK({rl, gl, bl}, 24'h1155_03)
    `CHK(sync_on, 1'b1)
    wreg(pdh_pkg::SEL_MASK, 8'hFE);
    px(24'hFFFF_11, 2'h0, 4'h0, 1'b1, 1'b1);
    `CHK({rl, gl, bl}, 24'h1122_03)
    px(24'h1234_56, 2'h1, 4'h0, 1'b1, 1'b1);
    `CHK({rl, gl, bl}, 24'h1234_56)
    px(24'h1234_56, 2'h1, 4'h3, 1'b1, 1'b1);
    `CHK({rl, gl, bl}, 24'h7A7B_7C)
    px(24'h1234_56, 2'h1, 4'h3, 1'b1, 1'b0);
    `CHK({rl, gl, bl, blank_act}, 25'h0_0000_01)
    `CHK(sync_on, 1'b1)
    px(24'h1234_56, 2'h1, 4'h0, 1'b0, 1'b0);
    `CHK({rl, gl, bl, blank_act, sync_on}, 26'h0_0000_02)
    px(24'h9876_54, 2'h1, 4'h0, 1'b1, 1'b1);
    `CHK({rl, gl, bl, blank_act}, 25'h1_30EC_A8)
    // Clock enable low must hold every output where it stands
    @(posedge clk);
    ce <= 1'b0;
    px(24'h0000_00, 2'h1, 4'h0, 1'b1, 1'b1);
    `CHK({rl, gl, bl, blank_act}, 25'h1_30EC_A8)
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK({rl, gl, bl}, 24'h0000_00)
    end_of_test;
  end
endmodule
